// *** include/dcwtq_regs.svh ***
// register offsets, field positions and reset values of the trigger and
// codeword qualifier; assumes a 32-bit apb slave with word-aligned offsets
`ifndef DCWTQ_REGS_SVH
`define DCWTQ_REGS_SVH

`define DCWTQ_ADDR_W        12
`define DCWTQ_CTRL_OFS      12'h000
`define DCWTQ_VALID_OFS     12'h004
`define DCWTQ_CWORD_OFS     12'h008
`define DCWTQ_STATUS_OFS    12'h00C
`define DCWTQ_HIGH_OFS      12'h010
`define DCWTQ_LOW_OFS       12'h014
`define DCWTQ_SYNC_OFS      12'h018
// ctrl fields
`define DCWTQ_CTRL_SLOPE_LO 0
`define DCWTQ_CTRL_SRC_LO   2
`define DCWTQ_CTRL_ZSEL_BIT 7
`define DCWTQ_CTRL_TCLR_BIT 8
`define DCWTQ_CTRL_ECLR_BIT 9
`define DCWTQ_CTRL_RST      32'h0000_0000
// valid fields
`define DCWTQ_VALID_IDX_LO  0
`define DCWTQ_VALID_POL_LO  8
`define DCWTQ_VALID_IDX_MIN 5'h10
`define DCWTQ_VALID_RST     32'h0000_0010
// codeword fields
`define DCWTQ_CW_MASK_LO    0
`define DCWTQ_CW_SHIFT_LO   16
`define DCWTQ_CW_RST        32'h0000_03FF
// status bits
`define DCWTQ_ST_TRIG_BIT   0
`define DCWTQ_ST_GEN_BIT    1
`define DCWTQ_ST_TERR_BIT   2
`define DCWTQ_ST_RUN_BIT    3

`endif

// *** include/dcwtq_pkg.sv ***
// types shared by the trigger and codeword qualifier
// assumes nothing of its surroundings
package dcwtq_pkg;
    // trigger slope choice
    typedef enum logic [1:0] {
        DCWTQ_RISE  = 2'h0,
        DCWTQ_FALL  = 2'h1,
        DCWTQ_LEVEL = 2'h2
    } dcwtq_slope_t;
    // valid polarity choice
    typedef enum logic [1:0] {
        DCWTQ_POL_NONE = 2'h0,
        DCWTQ_POL_LOW  = 2'h1,
        DCWTQ_POL_HIGH = 2'h2,
        DCWTQ_POL_BOTH = 2'h3
    } dcwtq_pol_t;
    // start gating states, one-hot
    typedef enum logic [2:0] {
        DCWTQ_IDLE = 3'b001,
        DCWTQ_WAIT = 3'b010,
        DCWTQ_RUN  = 3'b100
    } dcwtq_state_t;
endpackage : dcwtq_pkg

// *** rtl/dcwtq_core.sv ***
// trigger detection, codeword qualification and start gating for one
// sequencer core; assumes apb master on clk and port inputs synchronous
//
// Added by the designer: the APB slave port and the register addresses.
`include "dcwtq_regs.svh"

module dcwtq_core
    import dcwtq_pkg::*;
#(
    parameter int NSRC = 8,                   // digital trigger sources
    parameter int NCH  = 4,                   // synchronised channels
    parameter int CW_W = 10                   // codeword width
) (
    input  wire logic              clk,             // 10 MHz clock
    input  wire logic              reset,           // sync, active high
    input  wire logic              psel,            // apb select
    input  wire logic              penable,         // apb enable
    input  wire logic              pwrite,          // apb direction
    input  wire logic [11:0]       paddr,           // apb byte address
    input  wire logic [31:0]       pwdata,          // apb write data
    output logic      [31:0]       prdata,          // apb read data
    output logic                   pready,          // apb ready
    output logic                   pslverr,         // apb error
    input  wire logic [NSRC-1:0]   trig_src,        // digital trigger sources
    input  wire logic [31:0]       port_in,         // parallel_digital_port
    input  wire logic [31:0]       link_in,         // sync link data word
    input  wire logic [4:0]        strobe_idx,      // strobe bit index
    input  wire logic [NCH-1:0]    sync_en,         // channels with sync on
    input  wire logic [NCH-1:0]    chan_ready,      // channels ready
    output logic                   trig_out,        // trigger to sequencer
    output logic [CW_W-1:0]        play_wave_by_codeword, // waveform select
    output logic                   cw_valid,        // codeword strobe
    output logic                   start_all        // common start pulse
);
    // ---------------- register state ----------------
    logic [31:0] ctrl_r, ctrl_nxt;            // slope, source, data select
    logic [31:0] valid_r, valid_nxt;          // valid index and polarity
    logic [31:0] cw_r, cw_nxt;                // mask and shift
    logic [31:0] prdata_r, prdata_nxt;        // read data
    logic        pready_r, pready_nxt;        // access-phase answer
    logic        pslverr_r, pslverr_nxt;      // unmapped answer
    // ---------------- datapath state ----------------
    logic [31:0] samp_r, samp_nxt;            // sampled input word
    logic [31:0] high_r, high_nxt;            // high bit status
    logic [31:0] low_r, low_nxt;              // low bit status
    logic        tsel_r, tsel_nxt;            // delayed trigger source
    logic        trig_flag_r, trig_flag_nxt;  // sticky trigger detected
    logic        trig_r, trig_nxt;            // trigger pulse/level out
    logic        gen_r, gen_nxt;              // codeword trigger indicator
    logic        terr_r, terr_nxt;            // sticky timing error
    logic [CW_W-1:0] cw_out_r, cw_out_nxt;    // codeword register
    logic        cwv_r, cwv_nxt;              // codeword valid pulse
    dcwtq_state_t st_r, st_nxt;               // start gating state
    logic        start_r, start_nxt;          // start pulse

    // decoded fields
    dcwtq_slope_t slope;                      // selected slope
    dcwtq_pol_t   pol;                        // selected polarity
    logic [2:0]   src_sel;                    // trigger source index
    logic [4:0]   vidx;                       // valid index with bit 4 forced high
    logic [4:0]   shamt;                      // codeword shift
    logic [CW_W-1:0] mask;                    // codeword mask
    logic         wr_acc;                     // write in access phase
    logic         rd_acc;                     // read in access phase
    logic         wr_done;                    // write completes at this edge
    logic [31:0]  din;                        // selected data word
    logic [31:0]  shifted;                    // shifted input word
    logic         qual;                       // valid qualifier met
    logic         strobe_edge;                // strobe changed
    logic         data_chg;                   // valid/data changed

    // address decode used by read and write paths
    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == `DCWTQ_CTRL_OFS)   || (a == `DCWTQ_VALID_OFS) ||
                    (a == `DCWTQ_CWORD_OFS)  || (a == `DCWTQ_STATUS_OFS) ||
                    (a == `DCWTQ_HIGH_OFS)   || (a == `DCWTQ_LOW_OFS) ||
                    (a == `DCWTQ_SYNC_OFS);
    endfunction : is_mapped

    // field extraction
    always_comb begin
        slope   = dcwtq_slope_t'(ctrl_r[`DCWTQ_CTRL_SLOPE_LO +: 2]);
        src_sel = ctrl_r[`DCWTQ_CTRL_SRC_LO +: 3];
        pol     = dcwtq_pol_t'(valid_r[`DCWTQ_VALID_POL_LO +: 2]);
        vidx    = valid_r[`DCWTQ_VALID_IDX_LO +: 5] | `DCWTQ_VALID_IDX_MIN;
        shamt   = cw_r[`DCWTQ_CW_SHIFT_LO +: 5];
        mask    = cw_r[`DCWTQ_CW_MASK_LO +: CW_W];
        wr_acc  = psel && penable && pwrite;
        rd_acc  = psel && penable && !pwrite;
        wr_done = wr_acc && pready_r;
    end

    // apb slave: one wait state, answer on the second access cycle
    always_comb begin
        ctrl_nxt    = ctrl_r;
        valid_nxt   = valid_r;
        cw_nxt      = cw_r;
        prdata_nxt  = prdata_r;
        pready_nxt  = 1'b0;
        pslverr_nxt = 1'b0;
        // a write lands on the edge at which the master sees pready high
        if (wr_done) begin
            unique case (paddr)
                `DCWTQ_CTRL_OFS:  ctrl_nxt  = pwdata & 32'h0000_00FF;
                `DCWTQ_VALID_OFS: valid_nxt = pwdata & 32'h0000_031F;
                `DCWTQ_CWORD_OFS: cw_nxt    = pwdata & 32'h001F_03FF;
                default: ;
            endcase
        end
        // first access cycle: answer on the next edge, read data with it
        if (psel && penable && !pready_r) begin
            pready_nxt  = 1'b1;
            pslverr_nxt = !is_mapped(paddr);
            prdata_nxt  = 32'h0000_0000;
            if (rd_acc) begin
                unique case (paddr)
                    `DCWTQ_CTRL_OFS:   prdata_nxt = ctrl_r;
                    `DCWTQ_VALID_OFS:  prdata_nxt = valid_r | 32'h0000_0010;
                    `DCWTQ_CWORD_OFS:  prdata_nxt = cw_r;
                    `DCWTQ_STATUS_OFS: prdata_nxt = {28'h0000000, (st_r ==
                        DCWTQ_RUN), terr_r, gen_r, trig_flag_r};
                    `DCWTQ_HIGH_OFS:   prdata_nxt = high_r;
                    `DCWTQ_LOW_OFS:    prdata_nxt = low_r;
                    `DCWTQ_SYNC_OFS:   prdata_nxt = {24'h000000, 
                        4'(chan_ready), 4'(sync_en)};
                    default:           prdata_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    // trigger detection and sticky flags
    always_comb begin
        tsel_nxt      = trig_src[src_sel];
        trig_nxt      = 1'b0;
        unique case (slope)
            DCWTQ_RISE:  trig_nxt = tsel_nxt && !tsel_r;
            DCWTQ_FALL:  trig_nxt = !tsel_nxt && tsel_r;
            DCWTQ_LEVEL: trig_nxt = tsel_nxt;
            default:     trig_nxt = 1'b0;
        endcase
        trig_flag_nxt = trig_flag_r;
        if (wr_done && paddr == `DCWTQ_CTRL_OFS &&
            pwdata[`DCWTQ_CTRL_TCLR_BIT])
            trig_flag_nxt = 1'b0;
        if (trig_nxt)
            trig_flag_nxt = 1'b1;
    end

    // data sampling, qualification and codeword extraction
    always_comb begin
        din = ctrl_r[`DCWTQ_CTRL_ZSEL_BIT] ? link_in : port_in;
        samp_nxt = din;
        high_nxt = din;
        low_nxt  = ~din;
        shifted  = din >> shamt;
        unique case (pol)
            DCWTQ_POL_NONE: qual = 1'b1;
            DCWTQ_POL_LOW:  qual = !din[vidx];
            DCWTQ_POL_HIGH: qual = din[vidx];
            DCWTQ_POL_BOTH: qual = 1'b1;
            default:        qual = 1'b0;
        endcase
        strobe_edge = din[strobe_idx] ^ samp_r[strobe_idx];
        data_chg    = |((din ^ samp_r) & ~(32'h1 << strobe_idx));
        cwv_nxt     = strobe_edge && qual;
        cw_out_nxt  = cwv_nxt ? (shifted[CW_W-1:0] & mask)
                              : cw_out_r;
        gen_nxt     = cwv_nxt;
        terr_nxt    = terr_r;
        if (wr_done && paddr == `DCWTQ_CTRL_OFS &&
            pwdata[`DCWTQ_CTRL_ECLR_BIT])
            terr_nxt = 1'b0;
        if (strobe_edge && data_chg)
            terr_nxt = 1'b1;
    end

    // start gating across synchronised channels
    always_comb begin
        st_nxt    = st_r;
        start_nxt = 1'b0;
        unique case (st_r)
            DCWTQ_IDLE: if (|sync_en) st_nxt = DCWTQ_WAIT;
            DCWTQ_WAIT: begin
                if (~|sync_en) begin
                    st_nxt = DCWTQ_IDLE;
                end else if ((chan_ready & sync_en) == sync_en) begin
                    st_nxt    = DCWTQ_RUN;
                    start_nxt = 1'b1;
                end
            end
            DCWTQ_RUN:  if (~|sync_en) st_nxt = DCWTQ_IDLE;
            default:    st_nxt = DCWTQ_IDLE;
        endcase
    end

    // register all state
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_r      <= `DCWTQ_CTRL_RST;
            valid_r     <= `DCWTQ_VALID_RST;
            cw_r        <= `DCWTQ_CW_RST;
            prdata_r    <= 32'h0000_0000;
            pready_r    <= 1'b0;
            pslverr_r   <= 1'b0;
            samp_r      <= 32'h0000_0000;
            high_r      <= 32'h0000_0000;
            low_r       <= 32'h0000_0000;
            tsel_r      <= 1'b0;
            trig_flag_r <= 1'b0;
            trig_r      <= 1'b0;
            gen_r       <= 1'b0;
            terr_r      <= 1'b0;
            cw_out_r    <= '0;
            cwv_r       <= 1'b0;
            st_r        <= DCWTQ_IDLE;
            start_r     <= 1'b0;
        end else begin
            ctrl_r      <= ctrl_nxt;
            valid_r     <= valid_nxt;
            cw_r        <= cw_nxt;
            prdata_r    <= prdata_nxt;
            pready_r    <= pready_nxt;
            pslverr_r   <= pslverr_nxt;
            samp_r      <= samp_nxt;
            high_r      <= high_nxt;
            low_r       <= low_nxt;
            tsel_r      <= tsel_nxt;
            trig_flag_r <= trig_flag_nxt;
            trig_r      <= trig_nxt;
            gen_r       <= gen_nxt;
            terr_r      <= terr_nxt;
            cw_out_r    <= cw_out_nxt;
            cwv_r       <= cwv_nxt;
            st_r        <= st_nxt;
            start_r     <= start_nxt;
        end
    end

    // outputs straight from flip-flops
    assign prdata                = prdata_r;
    assign pready                = pready_r;
    assign pslverr               = pslverr_r;
    assign trig_out              = trig_r;
    assign play_wave_by_codeword = cw_out_r;
    assign cw_valid              = cwv_r;
    assign start_all             = start_r;

    // ---------------- checks ----------------
    trig_sticky_a: assert property (@(posedge clk) disable iff (reset)
        trig_r |-> trig_flag_r) else $error("trigger flag not set");
    rise_edge_a: assert property (@(posedge clk) disable iff (reset)
        (slope == DCWTQ_RISE && $rose(tsel_r) && $stable(ctrl_r))
        |=> $past(trig_r) || trig_r) else $error("rising edge missed");
    level_trig_a: assert property (@(posedge clk) disable iff (reset)
        (slope == DCWTQ_LEVEL && tsel_r && $stable(ctrl_r)) |-> trig_r)
        else $error("level trigger missing");
    valid_idx_a: assert property (@(posedge clk) disable iff (reset)
        vidx[4]) else $error("valid index below 16");
    cw_value_a: assert property (@(posedge clk) disable iff (reset)
        cwv_r |-> (cw_out_r & ~$past(mask)) == '0)
        else $error("codeword outside mask");
    high_low_a: assert property (@(posedge clk) disable iff (reset)
        !$past(reset) |-> (high_r == ~low_r))
        else $error("high and low disagree");
    terr_set_a: assert property (@(posedge clk) disable iff (reset)
        (strobe_edge && data_chg) |=> terr_r) else $error("timing error lost");
    sync_start_a: assert property (@(posedge clk) disable iff (reset)
        start_r |-> $past((chan_ready & sync_en) == sync_en && |sync_en))
        else $error("start before all ready");
    // falling edge of tsel_r in fall mode gives a pulse in the same cycle
    fall_edge_a: assert property (@(posedge clk) disable iff (reset)
        (slope == DCWTQ_FALL && $fell(tsel_r) && $stable(ctrl_r))
        |-> trig_r) else $error("falling edge missed");
    // low polarity refuses a strobe while the valid bit is high
    pol_low_a: assert property (@(posedge clk) disable iff (reset)
        (pol == DCWTQ_POL_LOW && din[vidx] && strobe_edge) |=> !cwv_r)
        else $error("codeword taken with valid high");
    // high polarity refuses a strobe while the valid bit is low
    pol_high_a: assert property (@(posedge clk) disable iff (reset)
        (pol == DCWTQ_POL_HIGH && !din[vidx] && strobe_edge) |=> !cwv_r)
        else $error("codeword taken with valid low");
    // codeword only moves together with its valid pulse
    cw_hold_a: assert property (@(posedge clk) disable iff (reset)
        $changed(cw_out_r) |-> cwv_r) else $error("codeword moved alone");
    // timing error stays set until software clears it
    terr_hold_a: assert property (@(posedge clk) disable iff (reset)
        (terr_r && !(wr_done && paddr == `DCWTQ_CTRL_OFS &&
        pwdata[`DCWTQ_CTRL_ECLR_BIT])) |=> terr_r)
        else $error("timing error dropped");
    // common start is a single pulse per arming
    start_once_a: assert property (@(posedge clk) disable iff (reset)
        start_r |=> !start_r) else $error("start pulse too long");
endmodule : dcwtq_core

// *** verif/dcwtq_ctl_model.sv ***
// partner model: external controller driving codewords on the port
// assumes the bench calls its tasks right after a rising clock edge
module dcwtq_ctl_model (
    input  wire logic        clk,   // bench clock
    output logic      [31:0] word   // parallel_digital_port value
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int STB = 31;        // strobe bit position
    initial word = 32'h0000_0000;
    // place a plain word on the port, strobe bit taken from the word as given
    task automatic put(input logic [31:0] d);
        word <= d;
        @(posedge clk);
    endtask : put
    // data and valid settle first, strobe toggles a cycle later, alone unless bad is set
    task automatic send(input logic [31:0] d, input logic [4:0] vi,
                        input logic vl, input logic bad);
        logic [31:0] w;
        w = d;
        w[vi] = vl;
        w[STB] = word[STB];
        word <= w;
        @(posedge clk);
        w[STB] = ~w[STB];
        if (bad) begin
            w[0] = ~w[0];           // deliberate clash for the error case
        end
        word <= w;
        repeat (4) @(posedge clk);  // hold data well past the strobe
    endtask : send
endmodule : dcwtq_ctl_model

// *** verif/testbench.sv ***
// self-checking bench for the trigger and codeword qualifier core
// assumes core, package, register header and partner model compiled
`include "dcwtq_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, reset, psel, penable, pwrite;  // clock, apb
    logic [11:0] paddr;                              // apb address
    logic [31:0] pwdata, prdata, w;                  // w: model word
    logic        pready, pslverr, use_link;          // use_link: source
    logic [7:0]  trig_src;                           // trigger lines
    logic [4:0]  strobe_idx;                         // strobe position
    logic [3:0]  sync_en, chan_ready;                // start gating
    logic        trig_out, cw_valid, start_all;      // core outputs
    logic [9:0]  cw, cw_last;                        // codeword seen
    wire  [31:0] port_in = use_link ? ~w : w;        // inverse when idle
    wire  [31:0] link_in = use_link ? w : ~w;        // inverse when idle
    int n_mismatch = 0, check_count = 0;
    int trig_cnt = 0, cw_cnt = 0, st_cnt = 0;        // pulse tallies
    dcwtq_core dut (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trig_src(trig_src), .port_in(port_in),
        .link_in(link_in), .strobe_idx(strobe_idx), .sync_en(sync_en),
        .chan_ready(chan_ready), .trig_out(trig_out),
        .play_wave_by_codeword(cw), .cw_valid(cw_valid),
        .start_all(start_all));
    dcwtq_ctl_model ctl (.clk(clk), .word(w));
    // clock generator
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // tally output pulses and keep the last codeword
    always @(posedge clk) begin
        trig_cnt <= trig_cnt + int'(trig_out === 1'b1);
        cw_cnt   <= cw_cnt + int'(cw_valid === 1'b1);
        st_cnt   <= st_cnt + int'(start_all === 1'b1);
        if (cw_valid === 1'b1) begin
            cw_last <= cw;
        end
    end
    // compare one value
    task automatic chk(input string nm, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one apb transfer, waits for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) n_mismatch++;
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    // read and compare the masked bits
    task automatic rdc(input string nm, input logic [11:0] a,
                       input logic [31:0] e, input logic [31:0] m);
        logic [31:0] r;
        logic        er;
        apb(1'b0, a, 32'h0, r, er);
        chk(nm, e, r & m);
    endtask : rdc
    // expected codeword: shift toward lsb, then mask
    function automatic logic [9:0] exp_cw(input logic [31:0] d,
                                          input logic [4:0] sh,
                                          input logic [9:0] m);
        logic [31:0] s;
        s = d >> sh;
        return s[9:0] & m;
    endfunction : exp_cw
    // source low, high three cycles, low; count trigger pulses
    task automatic trig_case(input logic [1:0] sl, input logic [2:0] s,
                             input int e);
        int c0;
        wr(`DCWTQ_CTRL_OFS, {27'h0, s, sl});
        trig_src <= ~(8'h01 << s);
        repeat (3) @(posedge clk);
        c0 = trig_cnt;
        trig_src <= 8'h01 << s;
        repeat (3) @(posedge clk);
        trig_src <= ~(8'h01 << s);
        repeat (4) @(posedge clk);
        chk("trigger pulses", e, trig_cnt - c0);
    endtask : trig_case
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test
    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end
    // main sequence
    initial begin
        logic [31:0] d, r;
        logic [4:0]  sh, vi;
        logic [9:0]  m;
        logic [2:0]  s;
        logic [1:0]  pol;
        logic        vl, er, ok;
        logic [3:0]  rdy [4];
        int          c0;
        rdy = '{4'h1, 4'h3, 4'h7, 4'hF};
        {reset, psel, penable, pwrite} = 4'hF & 4'h8;
        {paddr, pwdata, trig_src, sync_en, chan_ready} = '0;
        strobe_idx = 5'h1F;
        use_link = 1'b0;
        void'($urandom(32'h46AB));
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rdc("ctrl rst", `DCWTQ_CTRL_OFS, `DCWTQ_CTRL_RST, '1);
        rdc("valid rst", `DCWTQ_VALID_OFS, `DCWTQ_VALID_RST, '1);
        rdc("cword rst", `DCWTQ_CWORD_OFS, `DCWTQ_CW_RST, '1);
        rdc("trig flag", `DCWTQ_STATUS_OFS, 32'h0, 32'h1);
        apb(1'b1, 12'h01C, 32'hFFFF_FFFF, r, er);
        chk("unmapped err", 32'h1, {31'h0, er});
        apb(1'b0, 12'h01C, 32'h0, r, er);
        chk("unmapped data", 32'h0, r);
        wr(`DCWTQ_VALID_OFS, 32'h0000_0305);
        rdc("valid idx", `DCWTQ_VALID_OFS, 32'h0000_0315, '1);
        for (int i = 0; i < 3; i++) begin
            s = 3'($urandom % 8);
            trig_case(i[1:0], s, (i == 2) ? 3 : 1);
        end
        rdc("trig flag", `DCWTQ_STATUS_OFS, 32'h1, 32'h1);
        wr(`DCWTQ_CTRL_OFS, {23'h0, 1'b1, 3'h0, s, 2'h2});
        rdc("trig flag", `DCWTQ_STATUS_OFS, 32'h0, 32'h1);
        for (int i = 0; i < 16; i++) begin
            d   = $urandom;
            sh  = (i == 0) ? 5'd21 : 5'($urandom % 22);
            m   = (i == 0) ? 10'h3FF : 10'($urandom);
            vi  = 5'(16 + $urandom % 15);
            vl  = 1'($urandom);
            pol = 2'(i);
            d[vi] = vl;
            ok = pol == 2'h0 || pol == 2'h3 || ((pol == 2'h2) == vl);
            use_link <= i[2];
            wr(`DCWTQ_CTRL_OFS, {24'h0, i[2], 7'h0});
            wr(`DCWTQ_VALID_OFS, {22'h0, pol, 3'h0, vi});
            wr(`DCWTQ_CWORD_OFS, {11'h0, sh, 6'h0, m});
            c0 = cw_cnt;
            ctl.send(d, vi, vl, 1'b0);
            chk("cw pulses", {31'h0, ok}, cw_cnt - c0);
            if (ok) chk("codeword", exp_cw(d, sh, m), cw_last);
        end
        use_link <= 1'b0;
        wr(`DCWTQ_CTRL_OFS, 32'h0);
        wr(`DCWTQ_CTRL_OFS, 32'h0000_0200);
        rdc("timing err", `DCWTQ_STATUS_OFS, 32'h0, 32'h4);
        ctl.send($urandom, 5'd16, 1'b1, 1'b1);
        rdc("timing err", `DCWTQ_STATUS_OFS, 32'h4, 32'h4);
        wr(`DCWTQ_CTRL_OFS, 32'h0000_0200);
        rdc("timing err", `DCWTQ_STATUS_OFS, 32'h0, 32'h4);
        d = $urandom;
        ctl.put(d);
        repeat (3) @(posedge clk);
        rdc("high bits", `DCWTQ_HIGH_OFS, d, '1);
        rdc("low bits", `DCWTQ_LOW_OFS, ~d, '1);
        sync_en <= 4'hB;
        c0 = st_cnt;
        foreach (rdy[k]) begin
            chan_ready <= rdy[k];
            repeat (4) @(posedge clk);
            chk("start pulses", (k == 3) ? 1 : 0, st_cnt - c0);
        end
        rdc("sync reg", `DCWTQ_SYNC_OFS, 32'h0000_00FB, '1);
        rdc("running", `DCWTQ_STATUS_OFS, 32'h8, 32'h8);
        chk("start pulses", 1, st_cnt - c0);
        sync_en <= 4'h0;
        repeat (3) @(posedge clk);
        sync_en <= 4'hB;
        repeat (4) @(posedge clk);
        chk("start rearm", 2, st_cnt - c0);
        finish_test();
    end
endmodule : testbench
